// ### hw/three_wire_serial_io_pkg.sv
// Constants, register map and helpers for the three-wire serial interface
//
// How it works
// - While disabled no shifting occurs; the shift register is a plain byte register.
// - While disabled the serial in and out pins are port pins; so is the clock pin unless bit 4 is set.
// - Enable bit 7 clear stops shifting, clears bit counter, gives pins port function.
// - Mode bit 6 picks first bit: 0 sends MSB first, 1 sends LSB first.
// - Mode bit 5 is stored and read back but selects nothing; only basic mode is built.
// - Bit 4 set holds the clock pin high while disabled; enabled with an internal clock select drives clock while port latch bit 2 is clear.
// - Clock select 00 is the external pin clock; 01/10/11 divide by 16/32/64.
// - Each direction bit: 0 drives the pin, 1 releases it; reset loads all ones.
// - Basic mode moves whole bytes, one bit per serial clock period.
// - Shift on each falling clock edge; outgoing bit is held in an output latch.
// - Sample the serial input into the shift register on each rising clock edge.
// - After the eighth bit the transfer stops and the done flag is raised.
// - A shift register write while no transfer runs clears the output latch; serial out goes low only if enabled and port latch bit 1 is clear.
// - With mode bit 6 set, bit order is mirrored between bus and shift register on reads and writes.
// - A shift register write starts a transfer if enabled and no transfer runs.
// - Reset clears the mode register to all zeros.
// - Setting the enable bit after a data write does not start a transfer.
package three_wire_serial_io_pkg;

  localparam logic [15:0] ADDR_PORT_TWO_LATCH       = 16'hFF02;
  localparam logic [15:0] ADDR_SERIAL_SHIFT         = 16'hFF1A;
  localparam logic [15:0] ADDR_PORT_TWO_DIRECTION   = 16'hFF22;
  localparam logic [15:0] ADDR_SERIAL_MODE_CONTROL  = 16'hFF68;

  localparam logic [7:0] RESET_PORT_TWO_DIRECTION   = 8'hFF;
  localparam logic [7:0] RESET_SERIAL_MODE_CONTROL  = 8'h00;
  localparam logic [7:0] RESET_PORT_TWO_LATCH       = 8'h00;
  localparam logic [7:0] RESET_SERIAL_SHIFT         = 8'h00;
  localparam logic [7:0] MODE_WRITE_MASK            = 8'hF3;

  localparam int BIT_SERIAL_ENABLE      = 7;
  localparam int BIT_FIRST_BIT_SELECT   = 6;
  localparam int BIT_AUTO_TRANSFER      = 5;
  localparam int BIT_CLOCK_IDLE_CONTROL = 4;
  localparam int BIT_CLOCK_SELECT_HIGH  = 1;
  localparam int BIT_CLOCK_SELECT_LOW   = 0;

  localparam int PIN_SERIAL_IN    = 0;
  localparam int PIN_SERIAL_OUT   = 1;
  localparam int PIN_SERIAL_CLOCK = 2;

  localparam logic [1:0] CLOCK_EXTERNAL = 2'h0;
  localparam logic [1:0] CLOCK_DIV16    = 2'h1;
  localparam logic [1:0] CLOCK_DIV32    = 2'h2;

  localparam logic [6:0] DIVIDE_16 = 7'h10;
  localparam logic [6:0] DIVIDE_32 = 7'h20;
  localparam logic [6:0] DIVIDE_64 = 7'h40;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  function automatic logic [7:0] mirror_if(input logic [7:0] value, input logic reverse);
    logic [7:0] result;
    result = value;
    if (reverse) begin
      for (int i = 0; i < 8; i++) begin
        result[i] = value[7 - i];
      end
    end
    return result;
  endfunction

  function automatic logic [5:0] half_period(input logic [1:0] sel);
    logic [6:0] full;
    full = DIVIDE_64;
    if (sel == CLOCK_DIV16) begin
      full = DIVIDE_16;
    end else if (sel == CLOCK_DIV32) begin
      full = DIVIDE_32;
    end
    return full[6:1];
  endfunction

endpackage

// ### hw/serial_clock_if.sv
// Serial clock edges and control between the core and the clock generator
`timescale 1ns/1ps
`default_nettype none
interface serial_clock_if;
  logic [1:0] sel;
  logic       run;
  logic       ext_level;
  logic       fall;
  logic       rise;
  logic       sck;

  modport gen (input sel, input run, input ext_level, output fall, output rise, output sck);
  modport user (output sel, output run, output ext_level, input fall, input rise, input sck);
endinterface
`default_nettype wire

// ### hw/serial_clock_gen.sv
// Serial clock generator: divided system clock or external pin edges
`timescale 1ns/1ps
`default_nettype none
module serial_clock_gen
  import three_wire_serial_io_pkg::*;
(
  input wire logic     i_ref_clk,  // System clock
  input wire logic     i_srst,     // Synchronous reset
  serial_clock_if.gen  sc          // Edge and control bundle
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic       sck;
  logic       next_sck;
  logic       prev_ext;
  logic       next_prev_ext;
  logic       fall;
  logic       next_fall;
  logic       rise;
  logic       next_rise;

  always_comb begin
    next_cnt      = cnt;
    next_sck      = sck;
    next_prev_ext = sc.ext_level;
    next_fall     = 1'b0;
    next_rise     = 1'b0;
    if (sc.sel == CLOCK_EXTERNAL) begin
      next_cnt = 6'h00;
      next_sck = 1'b1;
      if (sc.run) begin
        next_fall = prev_ext & ~sc.ext_level;
        next_rise = ~prev_ext & sc.ext_level;
      end
    end else if (!sc.run) begin
      next_cnt = 6'h00;
      next_sck = 1'b1;
    end else if (cnt == 6'h00) begin
      next_sck  = ~sck;
      next_fall = sck;
      next_rise = ~sck;
      next_cnt  = half_period(sc.sel) - 6'h01;
    end else begin
      next_cnt = cnt - 6'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt      <= 6'h00;
      sck      <= 1'b1;
      prev_ext <= 1'b1;
      fall     <= 1'b0;
      rise     <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      sck      <= next_sck;
      prev_ext <= next_prev_ext;
      fall     <= next_fall;
      rise     <= next_rise;
    end
  end

  assign sc.fall = fall;
  assign sc.rise = rise;
  assign sc.sck  = sck;
endmodule
`default_nettype wire

// ### hw/three_wire_serial_io.sv
// Three-wire serial interface core with mode, direction and latch registers
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_io
  import three_wire_serial_io_pkg::*;
(
  input  wire logic        i_ref_clk,    // System clock, 100 MHz
  input  wire logic        i_srst,       // Synchronous reset, active high
  input  wire logic [15:0] i_addr,       // Register address
  input  wire logic        i_wr,         // Register write strobe
  input  wire logic        i_rd,         // Register read strobe
  input  wire logic [7:0]  i_wdata,      // Write data
  output logic      [7:0]  o_rdata,      // Read data, one cycle after i_rd
  input  wire logic [7:0]  i_port_in,    // Port two pin levels
  output logic      [7:0]  o_port_out,   // Port two pin drive values
  output logic      [7:0]  o_port_oe,    // Port two output enables
  output logic             o_done_pulse  // Transfer done flag set pulse
);
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [7:0] direction;
  logic [7:0] next_direction;
  logic [7:0] latch;
  logic [7:0] next_latch;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic       so_bit;
  logic       next_so_bit;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic       busy;
  logic       next_busy;
  logic       done;
  logic       next_done;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] port_out;
  logic [7:0] next_port_out;
  logic [7:0] port_oe;
  logic [7:0] next_port_oe;

  logic       enabled;
  logic       reverse;
  logic       internal_clk;
  logic       wr_mode;
  logic       wr_direction;
  logic       wr_latch;
  logic       wr_shift;

  serial_clock_if sc ();

  serial_clock_gen u_clock_gen (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .sc        (sc)
  );

  assign enabled      = mode[BIT_SERIAL_ENABLE];
  assign reverse      = mode[BIT_FIRST_BIT_SELECT];
  assign sc.sel       = {mode[BIT_CLOCK_SELECT_HIGH], mode[BIT_CLOCK_SELECT_LOW]};
  assign internal_clk = (sc.sel != CLOCK_EXTERNAL);
  assign sc.run       = busy & enabled;
  assign sc.ext_level = i_port_in[PIN_SERIAL_CLOCK];

  assign wr_mode      = i_wr && (i_addr == ADDR_SERIAL_MODE_CONTROL);
  assign wr_direction = i_wr && (i_addr == ADDR_PORT_TWO_DIRECTION);
  assign wr_latch     = i_wr && (i_addr == ADDR_PORT_TWO_LATCH);
  assign wr_shift     = i_wr && (i_addr == ADDR_SERIAL_SHIFT);

  // Registers and transfer engine
  always_comb begin
    next_mode      = mode;
    next_direction = direction;
    next_latch     = latch;
    next_shreg     = shreg;
    next_so_bit    = so_bit;
    next_bit_cnt   = bit_cnt;
    next_busy      = busy;
    next_done      = 1'b0;
    next_rdata     = rdata;

    if (wr_mode) begin
      next_mode = i_wdata & MODE_WRITE_MASK;
    end
    if (wr_direction) begin
      next_direction = i_wdata;
    end
    if (wr_latch) begin
      next_latch = i_wdata;
    end

    if (!enabled) begin
      next_busy    = 1'b0;
      next_bit_cnt = 4'h0;
    end else if (busy) begin
      if (sc.fall) begin
        next_so_bit = shreg[7];
        next_shreg  = {shreg[6:0], shreg[0]};
      end
      if (sc.rise) begin
        next_shreg[0] = i_port_in[PIN_SERIAL_IN];
        next_bit_cnt  = bit_cnt + 4'h1;
        if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
          next_busy    = 1'b0;
          next_done    = 1'b1;
          next_bit_cnt = 4'h0;
        end
      end
    end

    // Shift register writes during a running transfer are ignored
    if (wr_shift && !busy) begin
      next_shreg   = mirror_if(i_wdata, reverse);
      next_so_bit  = 1'b0;
      next_bit_cnt = 4'h0;
      next_busy    = enabled;
    end

    if (i_rd) begin
      unique case (i_addr)
        ADDR_SERIAL_MODE_CONTROL: next_rdata = mode;
        ADDR_PORT_TWO_DIRECTION:  next_rdata = direction;
        ADDR_PORT_TWO_LATCH:      next_rdata = latch;
        ADDR_SERIAL_SHIFT:        next_rdata = mirror_if(shreg, reverse);
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mode      <= RESET_SERIAL_MODE_CONTROL;
      direction <= RESET_PORT_TWO_DIRECTION;
      latch     <= RESET_PORT_TWO_LATCH;
      shreg     <= RESET_SERIAL_SHIFT;
      so_bit    <= 1'b0;
      bit_cnt   <= 4'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      mode      <= next_mode;
      direction <= next_direction;
      latch     <= next_latch;
      shreg     <= next_shreg;
      so_bit    <= next_so_bit;
      bit_cnt   <= next_bit_cnt;
      busy      <= next_busy;
      done      <= next_done;
      rdata     <= next_rdata;
    end
  end

  // Pin multiplexing
  always_comb begin
    next_port_oe  = ~direction;
    next_port_out = latch;
    if (enabled) begin
      next_port_out[PIN_SERIAL_OUT] = so_bit | latch[PIN_SERIAL_OUT];
      if (internal_clk) begin
        next_port_out[PIN_SERIAL_CLOCK] = sc.sck | latch[PIN_SERIAL_CLOCK];
      end
    end else if (mode[BIT_CLOCK_IDLE_CONTROL]) begin
      next_port_oe[PIN_SERIAL_CLOCK]  = 1'b1;
      next_port_out[PIN_SERIAL_CLOCK] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      port_oe  <= 8'h00;
      port_out <= 8'h00;
    end else begin
      port_oe  <= next_port_oe;
      port_out <= next_port_out;
    end
  end

  assign o_rdata      = rdata;
  assign o_port_out   = port_out;
  assign o_port_oe    = port_oe;
  assign o_done_pulse = done;
endmodule
`default_nettype wire

// ### verification/three_wire_serial_io_sva.sv
// Port assertions for the three-wire serial interface
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_io_sva
  import three_wire_serial_io_pkg::*;
(
  input wire logic        i_ref_clk,    // System clock
  input wire logic        i_srst,       // Synchronous reset
  input wire logic [15:0] i_addr,       // Register address
  input wire logic        i_wr,         // Write strobe
  input wire logic        i_rd,         // Read strobe
  input wire logic [7:0]  i_wdata,      // Write data
  input wire logic [7:0]  o_rdata,      // Read data
  input wire logic [7:0]  o_port_out,   // Pin drive values
  input wire logic [7:0]  o_port_oe,    // Pin enables
  input wire logic        o_done_pulse  // Transfer done
);
  logic [7:0] mode;
  logic [7:0] latch;
  logic [7:0] next_mode;
  logic [7:0] next_latch;
  wire logic  wm = i_wr && i_addr == ADDR_SERIAL_MODE_CONTROL;
  wire logic  ws = i_wr && i_addr == ADDR_SERIAL_SHIFT;
  wire logic  run = mode[7] && mode[1:0] != 2'h0 && !latch[2];
  // Shadow copies of mode and latch
  always_comb begin
    next_mode = wm ? (i_wdata & MODE_WRITE_MASK) : mode;
    next_latch = (i_wr && i_addr == ADDR_PORT_TWO_LATCH) ? i_wdata : latch;
  end
  always_ff @(posedge i_ref_clk) begin
    mode <= i_srst ? 8'h00 : next_mode;
    latch <= i_srst ? 8'h00 : next_latch;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  rst_clear_a: assert property (disable iff (1'b0) i_srst |=> o_port_oe == 8'h00)
    else $error("enables not cleared by reset");
  done_single_a: assert property (o_done_pulse |=> !o_done_pulse)
    else $error("done pulse longer than one cycle");
  mode_readback_a: assert property (wm ##2 (i_rd && i_addr == ADDR_SERIAL_MODE_CONTROL)
    |=> o_rdata == ($past(i_wdata, 3) & MODE_WRITE_MASK)) else $error("mode readback wrong");
  dir_enable_a: assert property (i_wr && i_addr == ADDR_PORT_TWO_DIRECTION
    |-> ##2 ((o_port_oe ^ ~$past(i_wdata, 2)) & 8'hFB) == 8'h00) else $error("enable mismatch");
  so_low_a: assert property (ws && mode[7] && !latch[1] |-> ##2 !o_port_out[1])
    else $error("serial out not low after write");
  clk_hold_a: assert property (wm && !i_wdata[7] && i_wdata[4]
    |-> ##2 o_port_oe[2] && o_port_out[2]) else $error("clock pin not held high");
  start_fall_a: assert property (ws && run |-> ##3 !o_port_out[2])
    else $error("transfer did not start");
  late_enable_a: assert property (wm && i_wdata[7] && !mode[7] && i_wdata[1:0] != 2'h0
    && !latch[2] |-> ##2 o_port_out[2] [*4]) else $error("enable alone started clock");
  cover property (o_done_pulse && mode[6]);
  cover property (o_done_pulse && mode[1:0] == 2'h0);
  cover property (wm && !i_wdata[7] && mode[7]);
endmodule
bind three_wire_serial_io three_wire_serial_io_sva sva (.i_ref_clk, .i_srst, .i_addr, .i_wr,
  .i_rd, .i_wdata, .o_rdata, .o_port_out, .o_port_oe, .o_done_pulse);
`default_nettype wire

// ### verification/far_peripheral.sv
// Far-side peripheral: samples serial out, returns a byte, may supply the clock
`timescale 1ns/1ps
`default_nettype none
module far_peripheral (
  input  wire logic i_sck,  // Clock level on the wire
  input  wire logic i_so,   // Serial out of the block
  output var  logic o_si,   // Serial in of the block
  output var  logic o_sck   // Clock when supplied from here
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  int         n_rise;
  initial begin
    o_si = 1'b1;
    o_sck = 1'b1;
    n_rise = 0;
  end
  task automatic arm(input logic [7:0] b);
    tx_byte = b;
    rx_byte = 8'h00;
    n_rise = 0;
  endtask
  always @(negedge i_sck) begin
    if (n_rise < 8)
      o_si = tx_byte[3'(7 - n_rise)];
  end
  always @(posedge i_sck) begin
    rx_byte = {rx_byte[6:0], i_so};
    n_rise++;
    // Line toggled 50 ns after the last bit is taken
    if (n_rise == 8) begin
      #50;
      o_si = ~o_si;
    end
  end
  // Clock stands high outside frames
  task automatic ext_clock(input int half);
    repeat (8) begin
      #half o_sck = 1'b0;
      #half o_sck = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench for the three-wire serial interface
`timescale 1ns/1ps
`default_nettype none
module tb;
  import three_wire_serial_io_pkg::*;
  logic            i_ref_clk;
  logic            i_srst;
  logic [15:0]     i_addr;
  logic            i_wr;
  logic            i_rd;
  logic [7:0]      i_wdata;
  logic [7:0]      o_rdata;
  logic [7:0]      o_port_out;
  logic [7:0]      o_port_oe;
  logic            o_done_pulse;
  logic            far_si;
  logic            far_sck;
  int              n_errors = 0;
  int              compares = 0;
  logic [7:0]      exp_q[$];
  wire logic [7:0] pins = (o_port_oe & o_port_out) | (~o_port_oe & {5'h1F, far_sck, 1'b1, far_si});
  three_wire_serial_io dut (.i_ref_clk, .i_srst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
    .i_port_in(pins), .o_port_out, .o_port_oe, .o_done_pulse);
  far_peripheral far (.i_sck(pins[2]), .i_so(pins[1]), .o_si(far_si), .o_sck(far_sck));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    i_wr = w;
    i_rd = !w;
    i_addr = a;
    i_wdata = d;
    @(posedge i_ref_clk);
    #1;
    i_wr = 1'b0;
    i_rd = 1'b0;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    return {<<{v}};
  endfunction
  task automatic wait_done(output int cyc);
    cyc = 0;
    while (o_done_pulse !== 1'b1 && cyc < 1200) begin
      @(posedge i_ref_clk);
      #1;
      cyc++;
    end
  endtask
  task automatic xfer(input logic [7:0] m, input logic [7:0] d, input logic [7:0] tx);
    int cyc;
    bus(1, ADDR_SERIAL_MODE_CONTROL, m);
    bus(1, ADDR_PORT_TWO_DIRECTION, (m[1:0] == 2'h0) ? 8'hFD : 8'hF9);
    // Let the clock pin settle to its new owner before arming
    @(posedge i_ref_clk);
    #1;
    far.arm(tx);
    exp_q.push_back(m[6] ? rev(d) : d);
    exp_q.push_back(m[6] ? rev(tx) : tx);
    bus(1, ADDR_SERIAL_SHIFT, d);
    if (m[1:0] == 2'h0)
      far.ext_clock(200);
    wait_done(cyc);
    if (m[1:0] != 2'h0)
      chk(8'(cyc / (4 << m[1:0])), 8'h0F);
    chk(far.rx_byte, exp_q.pop_front());
    chk(8'(far.n_rise), 8'h08);
    bus(0, ADDR_SERIAL_SHIFT, 8'h00);
    chk(o_rdata, exp_q.pop_front());
  endtask
  initial begin
    logic [7:0] r;
    int         cyc;
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    void'($urandom(73561));
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_srst = 1'b0;
    bus(0, ADDR_SERIAL_MODE_CONTROL, 8'h00);
    chk(o_rdata, 8'h00);
    bus(0, ADDR_PORT_TWO_DIRECTION, 8'h00);
    chk(o_rdata, 8'hFF);
    bus(0, 16'h0000, 8'h00);
    chk(o_rdata, 8'h00);
    r = 8'($urandom);
    bus(1, ADDR_SERIAL_SHIFT, r);
    bus(0, ADDR_SERIAL_SHIFT, 8'h00);
    chk(o_rdata, r);
    bus(1, ADDR_PORT_TWO_DIRECTION, r);
    bus(1, ADDR_PORT_TWO_LATCH, ~r);
    @(posedge i_ref_clk);
    #1;
    chk(o_port_oe, ~r);
    chk(o_port_out, ~r);
    bus(1, ADDR_SERIAL_MODE_CONTROL, 8'h7F);
    bus(0, ADDR_SERIAL_MODE_CONTROL, 8'h00);
    chk(o_rdata, 8'h73);
    chk({6'h00, o_port_oe[2], o_port_out[2]}, 8'h03);
    // Abort a running transfer by disabling
    bus(1, ADDR_PORT_TWO_LATCH, 8'h00);
    bus(1, ADDR_SERIAL_MODE_CONTROL, 8'h83);
    bus(1, ADDR_PORT_TWO_DIRECTION, 8'hF9);
    bus(1, ADDR_SERIAL_SHIFT, 8'($urandom));
    repeat (40) @(posedge i_ref_clk);
    bus(1, ADDR_SERIAL_MODE_CONTROL, 8'h03);
    wait_done(cyc);
    chk(8'(cyc >= 1200), 8'h01);
    bus(1, ADDR_SERIAL_SHIFT, 8'($urandom));
    bus(1, ADDR_SERIAL_MODE_CONTROL, 8'h81);
    wait_done(cyc);
    chk(8'(cyc >= 1200), 8'h01);
    for (int s = 0; s < 8; s++)
      xfer({1'b1, s[0], 4'h0, s[2:1]}, 8'($urandom), 8'($urandom));
    test_done();
  end
  initial begin
    #500000;
    n_errors++;
    test_done();
  end
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
